// ===== rtl/bpf_map.svh
// Register offsets, field positions and reset values of the pattern fill engine
`ifndef BPF_MAP_SVH
`define BPF_MAP_SVH
`define BPF_OFF_CTRL        8'h00
`define BPF_OFF_SRC         8'h04
`define BPF_OFF_DST         8'h08
`define BPF_OFF_DIM         8'h0c
`define BPF_OFF_PITCH       8'h10
`define BPF_OFF_COLOR       8'h14
`define BPF_OFF_STATUS      8'h18
`define BPF_CTRL_W          16
`define BPF_CTRL_RST        16'hf000
`define BPF_DIM_W_LSB       0
`define BPF_DIM_H_LSB       16
`define BPF_DIM_BITS        12
`define BPF_COLOR_FG_LSB    0
`define BPF_COLOR_BG_LSB    8
`define BPF_STAT_BUSY       0
`define BPF_STAT_DONE       1
`define BPF_STAT_ERR        2
`define BPF_KIND_PATTERN    2'h1
`define BPF_PAT_SIDE        8
`define BPF_PAT_ALIGN_BITS  6
`define BPF_LANES_ALL       4'hf
`define BPF_LANES_TEXT      4'h3
`define BPF_LANES_PACKED    4'h1
`endif

// ===== rtl/bpf_pkg.sv
// Types shared by the pattern fill engine
package bpf_pkg;
   typedef enum logic [4:0] {
      BPF_IDLE  = 5'h01,
      BPF_FETCH = 5'h02,
      BPF_PIXEL = 5'h04,
      BPF_RDDST = 5'h08,
      BPF_WRITE = 5'h10
   } bpf_state_type;

   typedef struct packed {
      logic [3:0] map_mask;
      logic       text_mode;
      logic       mono_trans;
      logic [1:0] rop;
      logic [2:0] plane_sel;
      logic       mono;
      logic       packed_mode;
      logic [1:0] src_kind;
      logic       start;
   } bpf_ctrl_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [3:0]  lanes;
      logic [19:0] addr;
      logic [31:0] wdata;
   } bpf_mreq_type;
endpackage

// ===== rtl/bpf_engine.sv
// Pattern fill block transfer engine with APB register slave
// Summary of operation
// - Tiling runs only when the source kind field selects pattern.
// - Source address picks anchor pixel; pattern wraps right and down.
// - Planar rows are eight consecutive addresses, base multiple of 64.
// - Packed byte n is top-left, n+7 top-right, n+63 bottom-right.
// - Monochrome pattern uses one selected plane of a colour pattern.
// - Each pattern row is read at the start of its destination row.
// - Text fills block writes to both font maps.
// - Destination-anchored first eight pixels replicate themselves during the fill.
// - Text-mode fills require planar addressing.
`timescale 1ns/1ps
`include "bpf_map.svh"
module bpf_engine #(
   parameter int AW = 20
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   output bpf_pkg::bpf_mreq_type     mem_o,
   input  wire logic                 mem_ack,
   input  wire logic [31:0]          mem_rdata
);
   if (AW != 20) begin : g_aw_check
      $error("AW must be 20 to match the memory carrier");
   end

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `BPF_OFF_CTRL) || (a == `BPF_OFF_SRC) || (a == `BPF_OFF_DST) ||
               (a == `BPF_OFF_DIM) || (a == `BPF_OFF_PITCH) || (a == `BPF_OFF_COLOR) ||
               (a == `BPF_OFF_STATUS);
   endfunction

   function automatic logic [31:0] rop_f(input logic [1:0] op, input logic [31:0] s,
                                         input logic [31:0] d);
      case (op)
         2'h0:    rop_f = s;
         2'h1:    rop_f = ~s;
         2'h2:    rop_f = s ^ d;
         default: rop_f = s & d;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bpf_pkg::bpf_state_type                state_r, state_nxt;
   bpf_pkg::bpf_ctrl_type                 ctrl_r, ctrl_nxt;
   bpf_pkg::bpf_mreq_type                 mreq_r, mreq_nxt;
   logic [AW-1:0]                         src_r, src_nxt;
   logic [AW-1:0]                         dst_r, dst_nxt;
   logic [AW-1:0]                         rowb_r, rowb_nxt;
   logic [31:0]                           dim_r, dim_nxt;
   logic [AW-1:0]                         pitch_r, pitch_nxt;
   logic [15:0]                           color_r, color_nxt;
   logic [`BPF_DIM_BITS-1:0]              dx_r, dx_nxt;
   logic [`BPF_DIM_BITS-1:0]              dy_r, dy_nxt;
   logic [2:0]                            k_r, k_nxt;
   logic [31:0]                           buf_r [`BPF_PAT_SIDE];
   logic [31:0]                           buf_nxt [`BPF_PAT_SIDE];
   logic [31:0]                           spix_r, spix_nxt;
   logic                                  done_r, done_nxt;
   logic                                  err_r, err_nxt;
   logic [31:0]                           prdata_r, prdata_nxt;

   logic                                  wr_acc;
   logic [`BPF_DIM_BITS-1:0]              width;
   logic [`BPF_DIM_BITS-1:0]              height;
   logic [2:0]                            row0;
   logic [2:0]                            col0;
   logic [2:0]                            prow;
   logic [2:0]                            sel;
   logic [31:0]                           pix;
   logic                                  mbit;
   logic [31:0]                           fg4;
   logic [31:0]                           bg4;
   logic [31:0]                           spix;
   logic [3:0]                            lanes;
   logic                                  adv;
   bpf_pkg::bpf_ctrl_type                 wctl;

   assign wr_acc  = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign prdata  = prdata_r;
   assign mem_o   = mreq_r;
   assign width   = dim_r[`BPF_DIM_W_LSB +: `BPF_DIM_BITS];
   assign height  = dim_r[`BPF_DIM_H_LSB +: `BPF_DIM_BITS];
   assign row0    = src_r[5:3];
   assign col0    = src_r[2:0];
   assign prow    = row0 + dy_r[2:0];
   assign sel     = col0 + dx_r[2:0];
   assign pix     = buf_r[sel];
   assign fg4     = {4{color_r[`BPF_COLOR_FG_LSB +: 8]}};
   assign bg4     = {4{color_r[`BPF_COLOR_BG_LSB +: 8]}};
   assign wctl    = bpf_pkg::bpf_ctrl_type'(pwdata[`BPF_CTRL_W-1:0]);
   // Mono: packed takes a bit of the byte, planar takes bit 0 of a map
   assign mbit    = ctrl_r.packed_mode ? pix[ctrl_r.plane_sel] :
                    pix[{ctrl_r.plane_sel[1:0], 3'h0}];
   assign spix    = ctrl_r.mono ? (mbit ? fg4 : bg4) : pix;
   assign lanes   = ctrl_r.map_mask &
                    (ctrl_r.text_mode ? `BPF_LANES_TEXT : `BPF_LANES_ALL) &
                    (ctrl_r.packed_mode ? `BPF_LANES_PACKED : `BPF_LANES_ALL);

   // ----------------------------------------------------------------
   // Next state: registers and engine
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt  = state_r;
      ctrl_nxt   = ctrl_r;
      mreq_nxt   = mreq_r;
      src_nxt    = src_r;
      dst_nxt    = dst_r;
      rowb_nxt   = rowb_r;
      dim_nxt    = dim_r;
      pitch_nxt  = pitch_r;
      color_nxt  = color_r;
      dx_nxt     = dx_r;
      dy_nxt     = dy_r;
      k_nxt      = k_r;
      buf_nxt    = buf_r;
      spix_nxt   = spix_r;
      done_nxt   = done_r;
      err_nxt    = err_r;
      prdata_nxt = prdata_r;
      adv        = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            `BPF_OFF_CTRL:   prdata_nxt = {16'h0, ctrl_r};
            `BPF_OFF_SRC:    prdata_nxt = {12'h0, src_r};
            `BPF_OFF_DST:    prdata_nxt = {12'h0, dst_r};
            `BPF_OFF_DIM:    prdata_nxt = dim_r;
            `BPF_OFF_PITCH:  prdata_nxt = {12'h0, pitch_r};
            `BPF_OFF_COLOR:  prdata_nxt = {16'h0, color_r};
            `BPF_OFF_STATUS: prdata_nxt = {29'h0, err_r, done_r, state_r != bpf_pkg::BPF_IDLE};
            default:         prdata_nxt = 32'h0;
         endcase
      end
      // Set/config writes are refused while busy so a fill sees stable setup
      if (wr_acc && state_r == bpf_pkg::BPF_IDLE) begin
         case (paddr)
            `BPF_OFF_CTRL:  ctrl_nxt  = wctl;
            `BPF_OFF_SRC:   src_nxt   = pwdata[AW-1:0];
            `BPF_OFF_DST:   dst_nxt   = pwdata[AW-1:0];
            `BPF_OFF_DIM:   dim_nxt   = pwdata;
            `BPF_OFF_PITCH: pitch_nxt = pwdata[AW-1:0];
            `BPF_OFF_COLOR: color_nxt = pwdata[15:0];
            default:        ;
         endcase
      end
      ctrl_nxt.start = 1'b0;
      if (wr_acc && paddr == `BPF_OFF_STATUS) begin
         done_nxt = done_nxt & ~pwdata[`BPF_STAT_DONE];
         err_nxt  = err_nxt & ~pwdata[`BPF_STAT_ERR];
      end
      case (state_r)
         bpf_pkg::BPF_IDLE: begin
            if (wr_acc && paddr == `BPF_OFF_CTRL && wctl.start) begin
               if (wctl.src_kind != `BPF_KIND_PATTERN) begin
                  err_nxt = 1'b1;
               end else if (wctl.text_mode && wctl.packed_mode) begin
                  err_nxt = 1'b1;
               end else if (width == '0 || height == '0) begin
                  done_nxt = 1'b1;
               end else begin
                  state_nxt = bpf_pkg::BPF_FETCH;
                  rowb_nxt  = dst_r;
                  dx_nxt    = '0;
                  dy_nxt    = '0;
               end
            end
         end
         bpf_pkg::BPF_FETCH: begin
            if (!mreq_r.req) begin
               mreq_nxt.req  = 1'b1;
               mreq_nxt.we   = 1'b0;
               mreq_nxt.addr = {src_r[AW-1:`BPF_PAT_ALIGN_BITS], prow, k_r};
            end else if (mem_ack) begin
               mreq_nxt.req = 1'b0;
               buf_nxt[k_r] = mem_rdata;
               k_nxt        = k_r + 3'h1;
               if (k_r == 3'h7) begin
                  state_nxt = bpf_pkg::BPF_PIXEL;
               end
            end
         end
         bpf_pkg::BPF_PIXEL: begin
            if (ctrl_r.mono && ctrl_r.mono_trans && !mbit) begin
               adv = 1'b1;
            end else begin
               mreq_nxt.req   = 1'b1;
               mreq_nxt.addr  = rowb_r + AW'(dx_r);
               mreq_nxt.lanes = lanes;
               spix_nxt       = spix;
               if (ctrl_r.rop[1]) begin
                  mreq_nxt.we = 1'b0;
                  state_nxt   = bpf_pkg::BPF_RDDST;
               end else begin
                  mreq_nxt.we    = 1'b1;
                  mreq_nxt.wdata = rop_f(ctrl_r.rop, spix, 32'h0);
                  state_nxt      = bpf_pkg::BPF_WRITE;
               end
            end
         end
         bpf_pkg::BPF_RDDST: begin
            if (mem_ack) begin
               mreq_nxt.we    = 1'b1;
               mreq_nxt.wdata = rop_f(ctrl_r.rop, spix_r, mem_rdata);
               state_nxt      = bpf_pkg::BPF_WRITE;
            end
         end
         bpf_pkg::BPF_WRITE: begin
            if (mem_ack) begin
               mreq_nxt.req = 1'b0;
               adv          = 1'b1;
            end
         end
         default: state_nxt = bpf_pkg::BPF_IDLE;
      endcase
      if (adv) begin
         state_nxt = bpf_pkg::BPF_PIXEL;
         dx_nxt    = dx_r + 1'b1;
         if (dx_nxt == width) begin
            dx_nxt   = '0;
            dy_nxt   = dy_r + 1'b1;
            rowb_nxt = rowb_r + pitch_r;
            k_nxt    = 3'h0;
            if (dy_nxt == height) begin
               state_nxt = bpf_pkg::BPF_IDLE;
               done_nxt  = 1'b1;
            end else begin
               state_nxt = bpf_pkg::BPF_FETCH;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r  <= bpf_pkg::BPF_IDLE;
         ctrl_r   <= bpf_pkg::bpf_ctrl_type'(`BPF_CTRL_RST);
         mreq_r   <= '0;
         src_r    <= '0;
         dst_r    <= '0;
         rowb_r   <= '0;
         dim_r    <= '0;
         pitch_r  <= '0;
         color_r  <= '0;
         dx_r     <= '0;
         dy_r     <= '0;
         k_r      <= '0;
         spix_r   <= '0;
         done_r   <= 1'b0;
         err_r    <= 1'b0;
         prdata_r <= '0;
         for (int i = 0; i < `BPF_PAT_SIDE; i++) begin
            buf_r[i] <= '0;
         end
      end else begin
         state_r  <= state_nxt;
         ctrl_r   <= ctrl_nxt;
         mreq_r   <= mreq_nxt;
         src_r    <= src_nxt;
         dst_r    <= dst_nxt;
         rowb_r   <= rowb_nxt;
         dim_r    <= dim_nxt;
         pitch_r  <= pitch_nxt;
         color_r  <= color_nxt;
         dx_r     <= dx_nxt;
         dy_r     <= dy_nxt;
         k_r      <= k_nxt;
         spix_r   <= spix_nxt;
         done_r   <= done_nxt;
         err_r    <= err_nxt;
         prdata_r <= prdata_nxt;
         buf_r    <= buf_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   wire start_wr = wr_acc && paddr == `BPF_OFF_CTRL && wctl.start &&
                   state_r == bpf_pkg::BPF_IDLE;
   a_kind_gate: assert property (start_wr && wctl.src_kind != `BPF_KIND_PATTERN |=>
      state_r == bpf_pkg::BPF_IDLE && err_r) else $error("non-pattern start ran");
   a_text_planar: assert property (start_wr && wctl.text_mode && wctl.packed_mode |=>
      state_r == bpf_pkg::BPF_IDLE && err_r) else $error("packed text fill started");
   a_fetch_addr: assert property (state_r == bpf_pkg::BPF_FETCH && mreq_r.req |->
      mreq_r.addr == {src_r[AW-1:6], prow, k_r}) else $error("bad pattern fetch address");
   a_row_refetch: assert property (state_r != bpf_pkg::BPF_IDLE && $changed(dy_r) |->
      state_r == bpf_pkg::BPF_FETCH && k_r == 3'h0) else $error("row not refetched");
   a_fetch_count: assert property ($rose(state_r == bpf_pkg::BPF_PIXEL) && dx_r == '0 |->
      $past(state_r) == bpf_pkg::BPF_FETCH && $past(k_r) == 3'h7) else $error("short fetch");
   a_font_block: assert property (mreq_r.req && mreq_r.we && ctrl_r.text_mode |->
      mreq_r.lanes[3:2] == 2'h0) else $error("font map written in text fill");
   a_anchor_pix: assert property (state_r == bpf_pkg::BPF_PIXEL && dx_r == '0 &&
      dy_r == '0 && !ctrl_r.mono && ctrl_r.rop == 2'h0 ##1 state_r == bpf_pkg::BPF_WRITE |->
      mreq_r.wdata == buf_r[col0]) else $error("anchor pixel misplaced");
   a_trans_skip: assert property (state_r == bpf_pkg::BPF_PIXEL && ctrl_r.mono &&
      ctrl_r.mono_trans && !mbit |=> !mreq_r.req) else $error("transparent pixel written");
   a_done_wins: assert property (state_r != bpf_pkg::BPF_IDLE && state_nxt ==
      bpf_pkg::BPF_IDLE |=> done_r) else $error("done lost at completion");
   a_req_hold: assert property (mreq_r.req && !mem_ack |=> mreq_r.req &&
      $stable(mreq_r.addr) && $stable(mreq_r.we)) else $error("memory request dropped");

   c_fill_done: cover property (state_r == bpf_pkg::BPF_WRITE ##1 done_r && !$past(done_r));
   c_mono_fill: cover property (state_r == bpf_pkg::BPF_WRITE && ctrl_r.mono && mem_ack);
   c_rop_read:  cover property (state_r == bpf_pkg::BPF_RDDST && mem_ack);
   c_wrap_col:  cover property (state_r == bpf_pkg::BPF_PIXEL && dx_r[2:0] == 3'h7 &&
      col0 != 3'h0);
endmodule

// ===== dv/bpf_mem_model.sv
// Display memory model on the far side of the pattern fill engine
`timescale 1ns/1ps
module bpf_mem_model (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire bpf_pkg::bpf_mreq_type mem_i,
   input  wire logic [3:0]            lat,
   output logic                       mem_ack,
   output logic [31:0]                mem_rdata
);
   logic [31:0] mem [0:4095];
   logic [31:0] last_r;
   logic [3:0]  wait_r;

   // ----------------------------------------
   // Access timing
   // ----------------------------------------
   // Idle bus shows the inverse of the last word, so stale data never passes
   assign mem_rdata = mem_ack ? last_r : ~last_r;

   always @(posedge clk) begin
      if (sys_rst) begin
         mem_ack <= 1'b0;
         wait_r  <= 4'h0;
         last_r  <= 32'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         wait_r  <= 4'h0;
      end else if (mem_i.req && wait_r >= lat) begin
         mem_ack <= 1'b1;
         if (mem_i.we) begin
            for (int i = 0; i < 4; i++) begin
               if (mem_i.lanes[i]) begin
                  mem[mem_i.addr[11:0]][8*i +: 8] <= mem_i.wdata[8*i +: 8];
               end
            end
         end else begin
            last_r <= mem[mem_i.addr[11:0]];
         end
      end else if (mem_i.req) begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule

// ===== dv/tb_blit_pattern_fill.sv
// Self-checking bench for the pattern fill engine
`timescale 1ns/1ps
`include "bpf_map.svh"
module tb_blit_pattern_fill;
   localparam logic [1:0] kp = `BPF_KIND_PATTERN;
   logic                  clk = 1'b0;
   logic                  sys_rst = 1'b1;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   bpf_pkg::bpf_mreq_type mem_o;
   logic                  mem_ack;
   logic [31:0]           mem_rdata;
   logic [3:0]            lat = 4'h0;
   logic [31:0]           rq;
   logic                  re;
   logic [31:0]           st;
   int                    fail_count = 0;
   int                    checks = 0;
   int                    cyc = 0;

   always #12.5 clk = ~clk;

   bpf_engine dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_o(mem_o), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   bpf_mem_model mem_u (.clk(clk), .sys_rst(sys_rst), .mem_i(mem_o), .lat(lat),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] pat(input logic [5:0] i);
      return {2'h3, ~i, 2'h2, i ^ 6'h15, 2'h1, i ^ 6'h2a, 2'h0, i};
   endfunction

   function automatic logic [5:0] ix(input logic [2:0] r, input logic [2:0] c,
                                     input int dy, input int dx);
      return {3'(r + dy), 3'(c + dx)};
   endfunction

   function automatic logic [31:0] px(input int o);
      return mem_u.mem[12'h600 + o];
   endfunction

   function automatic bpf_pkg::bpf_ctrl_type mk(input logic [1:0] k, input logic pk,
      input logic mo, input logic [2:0] ps, input logic [1:0] rp, input logic mt, input logic tx);
      return '{4'hf, tx, mt, rp, ps, mo, pk, k, 1'b1};
   endfunction

   task automatic load(input logic [11:0] b);
      for (int i = 0; i < 64; i++) mem_u.mem[b + i] = pat(6'(i));
   endtask

   task automatic fill(input logic [31:0] v);
      for (int a = 0; a < 256; a++) mem_u.mem[12'h600 + a] = v;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic go(input bpf_pkg::bpf_ctrl_type c, input logic [19:0] s, input int w,
                     input int h, input int pitch, input logic [15:0] col);
      apb(1'b1, `BPF_OFF_SRC, {12'h0, s});
      apb(1'b1, `BPF_OFF_DST, 32'h600);
      apb(1'b1, `BPF_OFF_DIM, {4'h0, 12'(h), 4'h0, 12'(w)});
      apb(1'b1, `BPF_OFF_PITCH, 32'(pitch));
      apb(1'b1, `BPF_OFF_COLOR, {16'h0, col});
      apb(1'b1, `BPF_OFF_CTRL, {16'h0, c});
   endtask

   task automatic waitst();
      repeat (2000) begin
         apb(1'b0, `BPF_OFF_STATUS, 32'h0);
         st = rq;
         if (rq[2:1] != 2'h0) break;
      end
      apb(1'b1, `BPF_OFF_STATUS, 32'h6);
   endtask

   task automatic report_and_stop();
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      apb(1'b0, `BPF_OFF_CTRL, 32'h0);
      chk("ctrl reset", {16'h0, `BPF_CTRL_RST}, rq);
      chk("ctrl slverr", 32'h0, {31'h0, re});
      apb(1'b0, `BPF_OFF_STATUS, 32'h0);
      chk("status reset", 32'h0, rq);
      apb(1'b1, `BPF_OFF_SRC, 32'hfff12345);
      apb(1'b0, `BPF_OFF_SRC, 32'h0);
      chk("src width", 32'h12345, rq);
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped data", 32'h0, rq);
      chk("unmapped slverr", 32'h1, {31'h0, re});
   endtask

   task automatic t_packed();
      logic [31:0] p;
      lat <= 4'h2;
      fill(32'h5a5a5a5a);
      go(mk(kp, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h5d, 10, 10, 16, 16'h0);
      waitst();
      chk("packed status", 32'h2, st);
      for (int dy = 0; dy < 11; dy++) begin
         for (int dx = 0; dx < 11; dx++) begin
            p = pat(ix(3'h3, 3'h5, dy, dx));
            p = (dx < 10 && dy < 10) ? {24'h5a5a5a, p[7:0]} : 32'h5a5a5a5a;
            chk("packed pixel", p, px(dy * 16 + dx));
         end
      end
   endtask

   task automatic t_rop();
      logic [31:0] p;
      for (int rp = 0; rp < 4; rp++) begin
         lat <= 4'(rp);
         fill(32'h96a53cf0);
         go(mk(kp, 1'b0, 1'b0, 3'h0, 2'(rp), 1'b0, 1'b0), 20'hb7, 9, 3, 16, 16'h0);
         waitst();
         for (int dy = 0; dy < 3; dy++) begin
            for (int dx = 0; dx < 9; dx++) begin
               p = pat(ix(3'h6, 3'h7, dy, dx));
               p = rp == 0 ? p : rp == 1 ? ~p : rp == 2 ? p ^ 32'h96a53cf0 : p & 32'h96a53cf0;
               chk("rop pixel", p, px(dy * 16 + dx));
            end
         end
      end
   endtask

   task automatic t_mono();
      logic [31:0] e;
      lat <= 4'h1;
      for (int mt = 0; mt < 3; mt++) begin
         fill(32'heeeeeeee);
         go(mk(kp, 1'(mt < 2), 1'b1, 3'h3, 2'h0, 1'(mt == 1), 1'b0), 20'h40, 8, 8, 16,
            16'h117e);
         waitst();
         for (int dy = 0; dy < 8; dy++) begin
            for (int dx = 0; dx < 8; dx++) begin
               e = dy[0] ? 32'heeeeee7e : (mt == 1 ? 32'heeeeeeee : 32'heeeeee11);
               // Planar mono reads bit 0 of map 3, which holds the inverted index
               if (mt == 2) e = dx[0] ? 32'h11111111 : 32'h7e7e7e7e;
               chk("mono pixel", e, px(dy * 16 + dx));
            end
         end
      end
   endtask

   task automatic t_text();
      logic [31:0] p;
      lat <= 4'h0;
      fill(32'haaaaaaaa);
      go(mk(kp, 1'b0, 1'b0, 3'h0, 2'h0, 1'b0, 1'b1), 20'h80, 8, 2, 16, 16'h0);
      waitst();
      for (int dy = 0; dy < 2; dy++) begin
         for (int dx = 0; dx < 8; dx++) begin
            p = pat(ix(3'h0, 3'h0, dy, dx));
            chk("text pixel", {16'haaaa, p[15:0]}, px(dy * 16 + dx));
         end
      end
      go(mk(kp, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b1), 20'h40, 8, 2, 16, 16'h0);
      waitst();
      chk("text packed status", 32'h4, st);
   endtask

   task automatic t_ondst();
      logic [31:0] p;
      logic [31:0] q;
      lat <= 4'h1;
      fill(32'h0);
      load(12'h680);
      go(mk(kp, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h680, 64, 3, 64, 16'h0);
      waitst();
      for (int dx = 0; dx < 64; dx++) begin
         p = pat(ix(3'h0, 3'h0, 2, dx));
         q = px(128 + dx);
         chk("last line pixel", {24'h0, p[7:0]}, {24'h0, q[7:0]});
      end
   endtask

   task automatic t_refuse();
      for (int k = 0; k < 4; k++) begin
         if (k == 1) continue;
         fill(32'h96a53cf0);
         go(mk(2'(k), 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h40, 4, 4, 16, 16'h0);
         waitst();
         chk("kind status", 32'h4, st);
         chk("kind no write", 32'h96a53cf0, px(0));
      end
      go(mk(kp, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h40, 0, 4, 16, 16'h0);
      waitst();
      chk("zero width status", 32'h2, st);
      chk("zero width no write", 32'h96a53cf0, px(0));
      lat <= 4'h8;
      go(mk(kp, 1'b1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h40, 10, 10, 16, 16'h0);
      apb(1'b1, `BPF_OFF_DST, 32'h700);
      apb(1'b0, `BPF_OFF_DST, 32'h0);
      chk("dst held busy", 32'h600, rq);
      apb(1'b0, `BPF_OFF_STATUS, 32'h0);
      chk("busy status", 32'h1, rq);
      waitst();
      chk("busy run status", 32'h2, st);
   endtask

   // One-row pattern seeded on the line, then widened by doubling transfers
   task automatic t_lines();
      lat <= 4'h1;
      fill(32'h0);
      for (int i = 0; i < 8; i++) mem_u.mem[12'h600 + i] = pat(6'(i));
      for (int w = 8; w <= 32; w = w * 2) begin
         go(mk(kp, 1'b0, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0), 20'h600, w, 1, 16, 16'h0);
         waitst();
         chk("line status", 32'h2, st);
      end
      apb(1'b0, `BPF_OFF_DST, 32'h0);
      chk("dst not advanced", 32'h600, rq);
      for (int dx = 0; dx < 33; dx++) begin
         chk("line pixel", dx < 32 ? pat(6'(dx % 8)) : 32'h0, px(dx));
      end
   endtask

   // ----------------------------------------
   // Sequence and timeout
   // ----------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      load(12'h40);
      load(12'h80);
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_packed();
      t_rop();
      t_mono();
      t_text();
      t_ondst();
      t_refuse();
      t_lines();
      report_and_stop();
   end
endmodule
